// [shared/hdr_pkg.sv]
`default_nettype none
package hdr_pkg;
   // register offsets on the processor bus
   localparam logic [7:0] REG_DMA_SETUP    = 8'hBC;
   localparam logic [7:0] REG_ASYNC_TMO    = 8'hC0;
   localparam logic [7:0] REG_BUF_ADDR_PTR = 8'hC4;
   localparam logic [7:0] REG_DATA_PORT    = 8'hC6;
   // dma_setup fields
   localparam int DS_COUNT_LSB   = 8;
   localparam int DS_DISABLE_BIT = 7;
   localparam int DS_BURST_LSB   = 2;
   localparam int DS_RUN_BIT     = 1;
   localparam int DS_DIR_BIT     = 0;
   localparam logic [31:0] DS_RESET      = 32'h0000_0000;
   localparam logic [31:0] TMO_RESET     = 32'h0000_0000;
   localparam logic [15:0] PTR_RESET     = 16'h0000;
   // timeout base: one second at the 20 MHz clock
   localparam int CLK_HZ          = 20_000_000;
   localparam int TMO_UNIT_S      = 1;
   localparam int SEC_CYCLES      = CLK_HZ * TMO_UNIT_S;
   // burst encodings
   localparam logic [1:0] BURST_SINGLE = 2'h0;
   localparam logic [1:0] BURST_4      = 2'h1;
   localparam logic [1:0] BURST_8      = 2'h2;
   localparam logic [1:0] BURST_16     = 2'h3;

   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } hdr_bus_req_t;

   typedef struct packed {
      logic        req;
      logic        wr;
      logic [15:0] addr;
      logic [15:0] wdata;
   } hdr_mem_req_t;
endpackage
`default_nettype wire

// [hdl/hdr_sec_tick.sv]
`timescale 1ns/10ps
`default_nettype none
module hdr_sec_tick #(
   parameter int DIV = 20_000_000
) (
   input  wire logic i_sys_clk, // system clock
   input  wire logic i_nrst,    // async reset, active low
   input  wire logic i_run,     // counting allowed
   output logic      o_tick     // one-cycle pulse per period
);
   logic [31:0] cnt_ff;
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cnt_ff <= 32'h0000_0000;
         o_tick <= 1'b0;
      end else if (!i_run) begin
         cnt_ff <= 32'h0000_0000;
         o_tick <= 1'b0;
      end else if (cnt_ff == 32'(DIV - 1)) begin
         cnt_ff <= 32'h0000_0000;
         o_tick <= 1'b1;
      end else begin
         cnt_ff <= cnt_ff + 32'h0000_0001;
         o_tick <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// [hdl/hdr_regs.sv]
`timescale 1ns/10ps
`default_nettype none
module hdr_regs #(
   parameter int SEC_DIV = hdr_pkg::SEC_CYCLES
) (
   input  wire logic                 i_sys_clk,    // system clock, 20 MHz
   input  wire logic                 i_nrst,       // async reset, active low
   input  wire hdr_pkg::hdr_bus_req_t i_bus,       // register access, same clock
   input  wire logic                 i_bus16,      // 1: 16-bit processor bus
   input  wire logic                 i_async_done, // async list descriptor completed
   input  wire logic                 i_burst_ack,  // dma burst finished by port
   input  wire logic [15:0]          i_mem_rdata,  // buffer memory read data
   output logic [31:0]               o_rdata,      // register read data
   output logic                      o_burst_req,  // dma burst requested
   output logic [4:0]                o_burst_size_select,  // cycles in current burst
   output logic                      o_dma_dir,    // 0 write RAM, 1 read RAM
   output logic                      o_dma_port_en,// dma data port usable
   output logic                      o_dma_done,   // byte count exhausted
   output logic                      o_irq,        // timeout interrupt line
   output hdr_pkg::hdr_mem_req_t     o_mem         // buffer memory access
);
   import hdr_pkg::*;

   typedef struct packed {
      logic [31:0]  setup;
      logic [31:0]  tmo;
      logic [15:0]  ptr;
      logic [23:0]  remain;
      logic         active;
      logic         burst_req;
      logic         done;
      logic         tmo_run;
      logic [31:0]  sec_cnt;
      logic         irq;
      logic [31:0]  rdata;
      hdr_mem_req_t mem;
   } hdr_state_t;

   hdr_state_t st_ff;
   hdr_state_t nxt_st;
   logic       sec_tick;

   function automatic logic [4:0] burst_cycles(input logic [1:0] sel);
      unique case (sel)
         BURST_SINGLE: burst_cycles = 5'h01;
         BURST_4:      burst_cycles = 5'h04;
         BURST_8:      burst_cycles = 5'h08;
         BURST_16:     burst_cycles = 5'h10;
      endcase
   endfunction

   // bytes moved by one burst: cycles times bus width in bytes
   function automatic logic [23:0] burst_bytes(input logic [1:0] sel, input logic b16);
      burst_bytes = b16 ? {18'h0, burst_cycles(sel), 1'b0} : {19'h0, burst_cycles(sel)};
   endfunction

   hdr_sec_tick #(.DIV(SEC_DIV)) u_tick (
      .i_sys_clk (i_sys_clk),
      .i_nrst    (i_nrst),
      .i_run     (st_ff.tmo_run),
      .o_tick    (sec_tick)
   );

   wire logic [1:0] bsel = st_ff.setup[DS_BURST_LSB +: 2];
   wire logic [23:0] bbytes = burst_bytes(bsel, i_bus16);
   wire logic        tmo_wr = i_bus.wr && (i_bus.addr == REG_ASYNC_TMO);

   always_comb begin
      nxt_st = st_ff;
      nxt_st.mem.req = 1'b0;
      nxt_st.irq = 1'b0;
      // register writes
      if (i_bus.wr) begin
         unique case (i_bus.addr)
            REG_DMA_SETUP: begin
               nxt_st.setup = {i_bus.wdata[31:8], i_bus.wdata[7], 3'h0, i_bus.wdata[3:0]};
               nxt_st.remain = i_bus.wdata[31:DS_COUNT_LSB];
               nxt_st.active = i_bus.wdata[DS_RUN_BIT];
               nxt_st.done = 1'b0;
               nxt_st.burst_req = 1'b0;
            end
            REG_ASYNC_TMO: begin
               nxt_st.tmo = i_bus.wdata;
               nxt_st.tmo_run = 1'b0;
            end
            REG_BUF_ADDR_PTR: nxt_st.ptr = i_bus.wdata[15:0];
            REG_DATA_PORT: begin
               nxt_st.mem.req = 1'b1;
               nxt_st.mem.wr = 1'b1;
               nxt_st.mem.addr = st_ff.ptr;
               nxt_st.mem.wdata = i_bus.wdata[15:0];
               nxt_st.ptr = st_ff.ptr + 16'h0001;
            end
            default: ;
         endcase
      end
      // reads; data port read advances the pointer
      if (i_bus.rd) begin
         unique case (i_bus.addr)
            REG_DMA_SETUP:    nxt_st.rdata = st_ff.setup;
            REG_ASYNC_TMO:    nxt_st.rdata = st_ff.tmo;
            REG_BUF_ADDR_PTR: nxt_st.rdata = {16'h0, st_ff.ptr};
            REG_DATA_PORT: begin
               nxt_st.rdata = {16'h0, i_mem_rdata};
               nxt_st.mem.req = 1'b1;
               nxt_st.mem.wr = 1'b0;
               nxt_st.mem.addr = st_ff.ptr;
               nxt_st.ptr = st_ff.ptr + 16'h0001;
            end
            default:          nxt_st.rdata = 32'h0000_0000;
         endcase
      end
      // dma burst sequencing
      if (st_ff.active && !(i_bus.wr && i_bus.addr == REG_DMA_SETUP)) begin
         if (!st_ff.setup[DS_DISABLE_BIT] && !st_ff.burst_req && st_ff.remain != 24'h0) begin
            nxt_st.burst_req = 1'b1;
         end
         if (st_ff.burst_req && i_burst_ack) begin
            nxt_st.burst_req = 1'b0;
            if (st_ff.remain <= bbytes) begin
               nxt_st.remain = 24'h0;
               nxt_st.active = 1'b0;
               nxt_st.done = 1'b1;
               nxt_st.setup[DS_RUN_BIT] = 1'b0;
            end else begin
               nxt_st.remain = st_ff.remain - bbytes;
            end
         end
         if (st_ff.remain == 24'h0) begin
            nxt_st.active = 1'b0;
            nxt_st.done = 1'b1;
         end
      end
      // async completion arms the seconds timer
      // a value rewrite stops the timer and beats a completion or expiry in the same cycle
      if (i_async_done && st_ff.tmo != 32'h0 && !tmo_wr) begin
         nxt_st.tmo_run = 1'b1;
         nxt_st.sec_cnt = 32'h0;
      end else if (st_ff.tmo_run && sec_tick && !tmo_wr) begin
         if (st_ff.sec_cnt + 32'h1 == st_ff.tmo) begin
            nxt_st.irq = 1'b1;
            nxt_st.tmo_run = 1'b0;
         end else begin
            nxt_st.sec_cnt = st_ff.sec_cnt + 32'h1;
         end
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_burst_size_select   <= 5'h01;
         o_dma_dir     <= 1'b0;
         o_dma_port_en <= 1'b1; // reset setup leaves the port enabled
      end else begin
         o_burst_size_select   <= burst_cycles(nxt_st.setup[DS_BURST_LSB +: 2]);
         o_dma_dir     <= nxt_st.setup[DS_DIR_BIT];
         o_dma_port_en <= ~nxt_st.setup[DS_DISABLE_BIT];
      end
   end

   assign o_rdata     = st_ff.rdata;
   assign o_burst_req = st_ff.burst_req;
   assign o_dma_done  = st_ff.done;
   assign o_irq       = st_ff.irq;
   assign o_mem       = st_ff.mem;

   a_ptr_read_inc: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      (i_bus.rd && i_bus.addr == REG_DATA_PORT && !i_bus.wr) |=> st_ff.ptr == $past(st_ff.ptr) + 16'h0001)
      else $error("pointer did not advance on read");
   a_ptr_write: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      (i_bus.wr && i_bus.addr == REG_BUF_ADDR_PTR && !i_bus.rd) |=> st_ff.ptr == $past(i_bus.wdata[15:0]))
      else $error("pointer not latched");
   a_count_field: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      (i_bus.wr && i_bus.addr == REG_DMA_SETUP) |=> st_ff.setup[31:8] == $past(i_bus.wdata[31:8]))
      else $error("byte count not stored");
   a_no_burst_dis: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      $rose(st_ff.burst_req) |-> !$past(st_ff.setup[DS_DISABLE_BIT]))
      else $error("burst while port disabled");
   a_burst_size_select_map: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      st_ff.setup[3:2] == BURST_16 |=> o_burst_size_select == 5'h10 || $changed(st_ff.setup))
      else $error("burst length mismatch");
   a_term_stops: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      (i_bus.wr && i_bus.addr == REG_DMA_SETUP && !i_bus.wdata[1]) |=> !st_ff.active ##1 !st_ff.burst_req)
      else $error("dma not terminated");
   a_done_stops: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      (st_ff.done && !i_bus.wr) |-> !st_ff.burst_req)
      else $error("burst after completion");
   a_irq_pulse: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      st_ff.irq |-> $past(st_ff.tmo_run) && st_ff.tmo != 32'h0 && !st_ff.tmo_run)
      else $error("interrupt without expiry");
endmodule
`default_nettype wire

// [dv/hdr_host_model.sv]
`timescale 1ns/10ps
`default_nettype none
module hdr_host_model (
   input  wire logic            i_sys_clk, // system clock
   input  wire logic [31:0]     i_rdata,   // register read data
   output hdr_pkg::hdr_bus_req_t o_bus     // register access strobes
);
   import hdr_pkg::*;
   initial begin
      o_bus = '0;
   end
   // one-cycle strobe; idle addr and data flip so stale values never pass
   task automatic access(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      @(negedge i_sys_clk);
      o_bus = '{rd: !wr, wr: wr, addr: a, wdata: d};
      @(negedge i_sys_clk);
      q = i_rdata;
      o_bus = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
   endtask
endmodule
`default_nettype wire

// [dv/tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import hdr_pkg::*;
   localparam int DIV = 10;
   logic          i_sys_clk = 1'b0;
   logic          i_nrst = 1'b0;
   logic          i_bus16 = 1'b0;
   logic          i_async_done = 1'b0;
   logic          i_burst_ack = 1'b0;
   logic [15:0]   i_mem_rdata = 16'h0000;
   hdr_bus_req_t  i_bus;
   hdr_mem_req_t  o_mem;
   logic [31:0]   o_rdata, q, v, seed = 32'h83E79F3C;
   logic [4:0]    o_burst_size_select;
   logic          o_burst_req, o_dma_dir, o_dma_port_en, o_dma_done, o_irq;
   logic [32:0]   seen[$];
   logic [7:0]    addrs[4] = '{REG_DMA_SETUP, REG_ASYNC_TMO, REG_BUF_ADDR_PTR, 8'h10};
   int            bad_count = 0, checks_done = 0, n, acks;
   always #25 i_sys_clk = ~i_sys_clk;
   always @(negedge i_sys_clk) i_mem_rdata <= seed[31:16];
   // sampled at the falling edge, where the registered request has settled
   always @(negedge i_sys_clk) if (o_mem.req === 1'b1) seen.push_back({o_mem.wr, o_mem.addr, o_mem.wdata});
   hdr_host_model host (.i_sys_clk(i_sys_clk), .i_rdata(o_rdata), .o_bus(i_bus));
   hdr_regs #(.SEC_DIV(DIV)) uut (
      .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_bus(i_bus), .i_bus16(i_bus16),
      .i_async_done(i_async_done), .i_burst_ack(i_burst_ack), .i_mem_rdata(i_mem_rdata),
      .o_rdata(o_rdata), .o_burst_req(o_burst_req), .o_burst_size_select(o_burst_size_select), .o_dma_dir(o_dma_dir),
      .o_dma_port_en(o_dma_port_en), .o_dma_done(o_dma_done), .o_irq(o_irq), .o_mem(o_mem));
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   function automatic int exp_len(input logic [1:0] code);
      return (code == 2'h0) ? 1 : (4 << (code - 1));
   endfunction
   function automatic int exp_bursts(input int cnt, input logic [1:0] code, input logic b16);
      int bpb;
      bpb = exp_len(code) * (b16 ? 2 : 1);
      return (cnt + bpb - 1) / bpb;
   endfunction
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic print_verdict();
      if (bad_count == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      #2_000_000;
      bad_count++;
      print_verdict();
   end
   initial begin
      repeat (6) @(negedge i_sys_clk);
      i_nrst = 1'b1;
      cmp(o_burst_size_select, 32'h1);
      cmp(o_dma_port_en, 1'b1);
      foreach (addrs[i]) begin
         host.access(1'b0, addrs[i], 32'h0, q);
         cmp(q, 32'h0);
      end
      for (int i = 0; i < 8; i++) begin
         seed = lfsr(seed);
         v = seed & 32'hFFFF_FF8D;
         // reserved bits written high must still read back low
         host.access(1'b1, REG_DMA_SETUP, v | 32'h70, q);
         host.access(1'b0, REG_DMA_SETUP, 32'h0, q);
         cmp(q, v);
         cmp(o_dma_dir, v[0]);
         cmp(o_dma_port_en, !v[7]);
         seed = lfsr(seed);
         host.access(1'b1, REG_ASYNC_TMO, seed, q);
         host.access(1'b0, REG_ASYNC_TMO, 32'h0, q);
         cmp(q, seed);
      end
      for (int c = 0; c < 8; c++) begin
         i_bus16 = c[2];
         seed = lfsr(seed);
         n = (c == 0) ? 32 : 1 + seed[7:0];
         host.access(1'b1, REG_DMA_SETUP, {n[23:0], 4'h0, c[1:0], 2'h2}, q);
         acks = 0;
         for (int w = 0; w < 600 && o_dma_done !== 1'b1; w++) begin
            @(negedge i_sys_clk);
            if (o_burst_req === 1'b1) begin
               cmp(o_burst_size_select, exp_len(c[1:0]));
               seed = lfsr(seed);
               // random stall keeps the request waiting
               repeat (seed[1:0]) @(negedge i_sys_clk);
               i_burst_ack = 1'b1;
               @(negedge i_sys_clk);
               i_burst_ack = 1'b0;
               acks++;
            end
         end
         cmp(acks, exp_bursts(n, c[1:0], c[2]));
         cmp(o_dma_done, 1'b1);
         repeat (5) @(negedge i_sys_clk);
         cmp(o_burst_req, 1'b0);
      end
      // run with the port disabled, then enable, then terminate mid-transfer
      i_bus16 = 1'b0;
      host.access(1'b1, REG_DMA_SETUP, 32'h0000_1082, q);
      acks = 0;
      repeat (10) @(negedge i_sys_clk) if (o_burst_req !== 1'b0) acks++;
      cmp(acks, 0);
      cmp(o_dma_port_en, 1'b0);
      host.access(1'b1, REG_DMA_SETUP, 32'h0000_1002, q);
      @(negedge i_sys_clk);
      cmp(o_burst_req, 1'b1);
      host.access(1'b1, REG_DMA_SETUP, 32'h0000_1000, q);
      acks = 0;
      repeat (10) @(negedge i_sys_clk) if (o_burst_req !== 1'b0) acks++;
      cmp(acks, 0);
      cmp(o_dma_done, 1'b0);
      seed = lfsr(seed);
      host.access(1'b1, REG_BUF_ADDR_PTR, {16'h0000, seed[15:0]}, q);
      host.access(1'b0, REG_BUF_ADDR_PTR, 32'h0, q);
      cmp(q, {16'h0000, seed[15:0]});
      seen.delete();
      for (int i = 0; i < 4; i++) begin
         host.access(1'b0, REG_DATA_PORT, 32'h0, q);
         cmp(q, {16'h0000, seed[31:16]});
      end
      host.access(1'b1, REG_DATA_PORT, v, q);
      repeat (2) @(negedge i_sys_clk);
      cmp(seen.size(), 5);
      for (int i = 0; i < 4 && i < seen.size(); i++) cmp(seen[i][32:16], {1'b0, seed[15:0] + i[15:0]});
      if (seen.size() == 5) begin
         cmp({seen[4][32], seen[4][15:0]}, {1'b1, v[15:0]});
         cmp(seen[4][31:16], seed[15:0] + 16'h0004);
      end
      host.access(1'b1, REG_ASYNC_TMO, 32'h3, q);
      i_async_done = 1'b1;
      @(negedge i_sys_clk);
      i_async_done = 1'b0;
      n = 0;
      while (o_irq !== 1'b1 && n < 100) begin
         @(negedge i_sys_clk);
         n++;
      end
      cmp(n >= 28 && n <= 31, 1'b1);
      @(negedge i_sys_clk);
      cmp(o_irq, 1'b0);
      host.access(1'b1, REG_ASYNC_TMO, 32'h0, q);
      i_async_done = 1'b1;
      @(negedge i_sys_clk);
      i_async_done = 1'b0;
      n = 0;
      repeat (60) @(negedge i_sys_clk) if (o_irq === 1'b1) n++;
      cmp(n, 0);
      // mid-run reset must bring every register back to its reset value
      host.access(1'b1, REG_DMA_SETUP, 32'h0000_1080, q);
      host.access(1'b1, REG_ASYNC_TMO, seed, q);
      @(negedge i_sys_clk);
      i_nrst = 1'b0;
      repeat (2) @(negedge i_sys_clk);
      i_nrst = 1'b1;
      cmp(o_dma_port_en, 1'b1);
      host.access(1'b0, REG_DMA_SETUP, 32'h0, q);
      cmp(q, DS_RESET);
      host.access(1'b0, REG_ASYNC_TMO, 32'h0, q);
      cmp(q, TMO_RESET);
      host.access(1'b0, REG_BUF_ADDR_PTR, 32'h0, q);
      cmp(q, {16'h0000, PTR_RESET});
      print_verdict();
   end
endmodule
`default_nettype wire
